// ===== rtl/pmr_phy_mgmt_regs.sv
// Overview of operation
// - Partner remote fault sets the local remote-fault status output.
// - Partner pause bits read one when either side has negotiation off.
// - With negotiation off, pause comes from local advertised pause bits.
// - Parallel detection fault latches high until expansion is read.
// - Partner next-page and negotiation-able read zero in fiber or off.
// - New page latches page-received; device reports next-page able.
// - Next-page transmit word writable except toggle and bit 14.
// - Partner next-page word is presented read-only as received.
// - Shared power-saving enable resets to one and enables the mode.
// - Shared far-end-fault bit disables the function when set.
// - Special status shows link, speed and duplex, zero on other pages.
// - Function field selects address, data, or data with increments.
// - Control holds five-bit device address; middle bits read zero.
// - Address/data reaches address register or data at stored address.
// - Clock-stop enable, reset zero, allows stopping receive clock.
// - Transmit and receive low-power-idle flags latch until read.
// - Live low-power-idle indications follow the current state.
// - Efficiency capability reads one only for 100BASE-TX.
// - Sixteen-bit wake error counter counts late wake sequences.
// - Only 100BASE-TX advertisement bit writable, reset one.
// - Shared five-bit page select chooses the page for registers 16 and 18; 20 reads on any page.
// - Latching bits hold after the cause ends until their read.
`timescale 1ns/10ps
module pmr_phy_mgmt_regs #(
  parameter int         NUM_PHY  = pmr_pkg::NUM_PHY,
  parameter logic [4:0] PHY_BASE = pmr_pkg::PHY_BASE_ADDR
)
(
  input  wire logic                                    clock_in,
  input  wire logic                                    rst_n_in,
  input  wire pmr_pkg::pmr_mgmt_req_t                  mgmt_in,
  input  wire pmr_pkg::pmr_phy_status_t [NUM_PHY-1:0]  phy_status_in,
  output logic                                         mgmt_ack_out,
  output logic                          [15:0]         mgmt_rdata_out,
  output pmr_pkg::pmr_phy_ctrl_t        [NUM_PHY-1:0]  phy_ctrl_out,
  output pmr_pkg::pmr_shared_ctrl_t                    shared_ctrl_out
);

  localparam int IW = (NUM_PHY > 1) ? $clog2(NUM_PHY) : 1;

  logic [5:0]                offset_w;
  logic                      hit;
  logic [IW-1:0]             sel;
  logic                      rd;
  logic                      wr;
  pmr_pkg::pmr_phy_status_t  st;
  pmr_pkg::pmr_mmd_fn_t      cur_fn;
  logic                      an_off;
  logic                      nego_gate;
  logic                      data_acc;
  logic                      step_addr;
  logic [15:0]               mmd_data;
  logic                      mmd_pcs_stat;
  logic                      mmd_wake;
  logic                      primary_page;
  logic [15:0]               rdata;
  pmr_pkg::pmr_phy_ctrl_t    [NUM_PHY-1:0] ctrl_q;
  pmr_pkg::pmr_phy_ctrl_t    [NUM_PHY-1:0] ctrl_d;
  pmr_pkg::pmr_mmd_fn_t      fn_q       [NUM_PHY];
  pmr_pkg::pmr_mmd_fn_t      fn_d       [NUM_PHY];
  logic [4:0]                devad_q    [NUM_PHY];
  logic [4:0]                devad_d    [NUM_PHY];
  logic [15:0]               mmd_addr_q [NUM_PHY];
  logic [15:0]               mmd_addr_d [NUM_PHY];
  logic [15:0]               wake_cnt   [NUM_PHY];
  logic [NUM_PHY-1:0]        pdf_lat;
  logic [NUM_PHY-1:0]        prx_lat;
  logic [NUM_PHY-1:0]        txl_lat;
  logic [NUM_PHY-1:0]        rxl_lat;
  logic [NUM_PHY-1:0]        clr_exp;
  logic [NUM_PHY-1:0]        clr_pcs;
  logic [NUM_PHY-1:0]        clr_wake;
  pmr_pkg::pmr_shared_ctrl_t shared_q;
  pmr_pkg::pmr_shared_ctrl_t shared_d;
  logic                      ack_q;
  logic                      ack_d;
  logic [15:0]               rdata_q;
  logic [15:0]               rdata_d;

  // Only PHY addresses of this bank answer; others belong elsewhere
  always_comb
  begin
    offset_w = {1'b0, mgmt_in.phy_addr} - {1'b0, PHY_BASE};
    hit      = mgmt_in.valid && !offset_w[5] && (offset_w < 6'(NUM_PHY));
    sel      = offset_w[IW-1:0];
    rd       = hit && !mgmt_in.write;
    wr       = hit && mgmt_in.write;
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PHY; g++)
    begin : g_phy
      pmr_sticky u_pdf (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .set_in   (phy_status_in[g].parallel_fault),
        .clr_in   (clr_exp[g]),
        .q_out    (pdf_lat[g])
      );
      pmr_sticky u_prx (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .set_in   (phy_status_in[g].page_received),
        .clr_in   (clr_exp[g]),
        .q_out    (prx_lat[g])
      );
      pmr_sticky u_txl (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .set_in   (phy_status_in[g].tx_lpi),
        .clr_in   (clr_pcs[g]),
        .q_out    (txl_lat[g])
      );
      pmr_sticky u_rxl (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .set_in   (phy_status_in[g].rx_lpi),
        .clr_in   (clr_pcs[g]),
        .q_out    (rxl_lat[g])
      );
      pmr_sat_counter #(.WIDTH (16)) u_wake (
        .clock_in  (clock_in),
        .rst_n_in  (rst_n_in),
        .inc_in    (phy_status_in[g].wake_error),
        .clr_in    (clr_wake[g]),
        .count_out (wake_cnt[g])
      );
    end
  endgenerate

  // Indirect register view of the selected PHY
  always_comb
  begin
    st           = phy_status_in[sel];
    cur_fn       = fn_q[sel];
    data_acc     = cur_fn != pmr_pkg::MMD_FN_ADDR;
    mmd_data     = '0;
    mmd_pcs_stat = 1'b0;
    mmd_wake     = 1'b0;
    if (devad_q[sel] == pmr_pkg::MMD_DEV_PCS)
    begin
      case (mmd_addr_q[sel])
        pmr_pkg::MMD_PCS_CONTROL1:
          mmd_data[pmr_pkg::BIT_CLK_STOP] = ctrl_q[sel].clock_stop_enable;
        pmr_pkg::MMD_PCS_STATUS1:
        begin
          mmd_pcs_stat = 1'b1;
          mmd_data[pmr_pkg::BIT_TX_LPI_LATCH] = txl_lat[sel];
          mmd_data[pmr_pkg::BIT_RX_LPI_LATCH] = rxl_lat[sel];
          mmd_data[pmr_pkg::BIT_TX_LPI_NOW]   = st.tx_lpi;
          mmd_data[pmr_pkg::BIT_RX_LPI_NOW]   = st.rx_lpi;
        end
        pmr_pkg::MMD_EEE_CAP:
          mmd_data = pmr_pkg::EEE_CAP_VALUE;
        pmr_pkg::MMD_WAKE_ERR:
        begin
          mmd_wake = 1'b1;
          mmd_data = wake_cnt[sel];
        end
        default:
          mmd_data = '0;
      endcase
    end
    else if (devad_q[sel] == pmr_pkg::MMD_DEV_AN)
    begin
      case (mmd_addr_q[sel])
        pmr_pkg::MMD_EEE_ADV:
          mmd_data[pmr_pkg::BIT_EEE_100TX] = ctrl_q[sel].eee_adv_100tx;
        pmr_pkg::MMD_EEE_PARTNER:
          mmd_data[pmr_pkg::BIT_EEE_100TX] = st.eee_partner_100tx;
        default:
          mmd_data = '0;
      endcase
    end
  end

  // Read multiplexer
  always_comb
  begin
    an_off       = !st.local_an_enable || !st.partner_an_able;
    nego_gate    = st.local_an_enable && !st.fiber_100mb_mode;
    primary_page = shared_q.upper_register_page_select
                   == pmr_pkg::PAGE_PRIMARY;
    rdata        = '0;
    case (mgmt_in.reg_addr)
      pmr_pkg::REG_PARTNER_BASE:
      begin
        rdata = st.partner_base;
        rdata[pmr_pkg::BIT_BASE_RSVD] = 1'b0;
        if (an_off)
          rdata[pmr_pkg::BIT_ASYM_PAUSE:pmr_pkg::BIT_SYM_PAUSE] =
            2'b11;
      end
      pmr_pkg::REG_NEG_EXPANSION:
      begin
        rdata[pmr_pkg::BIT_PDF]        = pdf_lat[sel];
        rdata[pmr_pkg::BIT_PARTNER_NP] = st.partner_base[pmr_pkg::BIT_NP]
                                         && nego_gate;
        rdata[pmr_pkg::BIT_NP_ABLE]    = 1'b1;
        rdata[pmr_pkg::BIT_PAGE_RX]    = prx_lat[sel];
        rdata[pmr_pkg::BIT_PARTNER_AN] = st.partner_an_able
                                         && nego_gate;
      end
      pmr_pkg::REG_NP_TRANSMIT:
      begin
        rdata = ctrl_q[sel].next_page_word;
        rdata[pmr_pkg::BIT_TOGGLE] = st.toggle;
      end
      pmr_pkg::REG_PARTNER_NP:
        rdata = st.partner_next_page;
      pmr_pkg::REG_MMD_CONTROL:
      begin
        rdata[pmr_pkg::FN_MSB:pmr_pkg::FN_LSB] = cur_fn;
        rdata[pmr_pkg::DEVAD_MSB:0] = devad_q[sel];
      end
      pmr_pkg::REG_MMD_ADDR_DATA:
        rdata = data_acc ? mmd_data : mmd_addr_q[sel];
      pmr_pkg::REG_SPECIAL_CTRL:
        if (primary_page)
        begin
          rdata[pmr_pkg::BIT_APS] = shared_q.advanced_power_saving;
          rdata[pmr_pkg::BIT_FEF_DISABLE] = shared_q.far_end_fault_disable;
        end
      pmr_pkg::REG_SPECIAL_STAT:
        if (primary_page)
        begin
          rdata[pmr_pkg::BIT_LINK_UP]     = st.link_up;
          rdata[pmr_pkg::BIT_SPEED_100]   = st.speed_100;
          rdata[pmr_pkg::BIT_FULL_DUPLEX] = st.full_duplex;
        end
      pmr_pkg::REG_PAGE_CONTROL:
        rdata[pmr_pkg::PAGE_SEL_MSB:0] = shared_q.upper_register_page_select;
      default:
        rdata = '0;
    endcase
  end

  // Next state for writes, side effects of reads and status tracking
  always_comb
  begin
    ctrl_d    = ctrl_q;
    shared_d  = shared_q;
    clr_exp   = '0;
    clr_pcs   = '0;
    clr_wake  = '0;
    ack_d     = hit;
    rdata_d   = rd ? rdata : '0;
    step_addr = data_acc && ((cur_fn == pmr_pkg::MMD_FN_DATA_INC_RW)
                || (cur_fn == pmr_pkg::MMD_FN_DATA_INC_WR && wr));
    for (int i = 0; i < NUM_PHY; i++)
    begin
      fn_d[i]       = fn_q[i];
      devad_d[i]    = devad_q[i];
      mmd_addr_d[i] = mmd_addr_q[i];
      ctrl_d[i].remote_fault =
        phy_status_in[i].partner_base[pmr_pkg::BIT_REMOTE_FAULT];
      if (!phy_status_in[i].local_an_enable
          || !phy_status_in[i].partner_an_able)
        ctrl_d[i].pause_resolved =
          phy_status_in[i].local_pause_adv;
      else
        ctrl_d[i].pause_resolved = phy_status_in[i].local_pause_adv
          & phy_status_in[i].partner_base[pmr_pkg::BIT_ASYM_PAUSE:
                                           pmr_pkg::BIT_SYM_PAUSE];
    end
    if (rd && mgmt_in.reg_addr == pmr_pkg::REG_NEG_EXPANSION)
      clr_exp[sel] = 1'b1;
    if (rd && mgmt_in.reg_addr == pmr_pkg::REG_MMD_ADDR_DATA && data_acc)
    begin
      clr_pcs[sel]  = mmd_pcs_stat;
      clr_wake[sel] = mmd_wake;
    end
    if (hit && mgmt_in.reg_addr == pmr_pkg::REG_MMD_ADDR_DATA && step_addr)
      mmd_addr_d[sel] = mmd_addr_q[sel] + 16'h0001;
    if (wr)
    begin
      case (mgmt_in.reg_addr)
        pmr_pkg::REG_NP_TRANSMIT:
        begin
          ctrl_d[sel].next_page_word = mgmt_in.wdata;
          ctrl_d[sel].next_page_word[pmr_pkg::BIT_NPT_RSVD] = 1'b0;
          ctrl_d[sel].next_page_word[pmr_pkg::BIT_TOGGLE]   = 1'b0;
        end
        pmr_pkg::REG_MMD_CONTROL:
        begin
          fn_d[sel] = pmr_pkg::pmr_mmd_fn_t'(
            mgmt_in.wdata[pmr_pkg::FN_MSB:pmr_pkg::FN_LSB]);
          devad_d[sel] = mgmt_in.wdata[pmr_pkg::DEVAD_MSB:0];
        end
        pmr_pkg::REG_MMD_ADDR_DATA:
        begin
          if (!data_acc)
            mmd_addr_d[sel] = mgmt_in.wdata;
          else if (devad_q[sel] == pmr_pkg::MMD_DEV_PCS
                   && mmd_addr_q[sel] == pmr_pkg::MMD_PCS_CONTROL1)
            ctrl_d[sel].clock_stop_enable =
              mgmt_in.wdata[pmr_pkg::BIT_CLK_STOP];
          else if (devad_q[sel] == pmr_pkg::MMD_DEV_AN
                   && mmd_addr_q[sel] == pmr_pkg::MMD_EEE_ADV)
            ctrl_d[sel].eee_adv_100tx =
              mgmt_in.wdata[pmr_pkg::BIT_EEE_100TX];
        end
        pmr_pkg::REG_SPECIAL_CTRL:
          if (primary_page)
          begin
            shared_d.advanced_power_saving =
              mgmt_in.wdata[pmr_pkg::BIT_APS];
            shared_d.far_end_fault_disable =
              mgmt_in.wdata[pmr_pkg::BIT_FEF_DISABLE];
          end
        pmr_pkg::REG_PAGE_CONTROL:
          shared_d.upper_register_page_select =
            mgmt_in.wdata[pmr_pkg::PAGE_SEL_MSB:0];
        // Reserved locations swallow writes so nothing odd is steered
        default:
          shared_d = shared_q;
      endcase
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      ack_q    <= 1'b0;
      rdata_q  <= '0;
      shared_q <= '{advanced_power_saving: pmr_pkg::APS_RESET,
                   far_end_fault_disable: pmr_pkg::FEF_RESET,
                   upper_register_page_select: pmr_pkg::PAGE_SEL_RESET};
      for (int i = 0; i < NUM_PHY; i++)
      begin
        ctrl_q[i]     <= '{next_page_word: pmr_pkg::NPT_RESET,
                           remote_fault: 1'b0,
                           pause_resolved: 2'b00,
                           clock_stop_enable: pmr_pkg::CLK_STOP_RESET,
                           eee_adv_100tx: pmr_pkg::EEE_ADV_RESET};
        fn_q[i]       <= pmr_pkg::MMD_FN_ADDR;
        devad_q[i]    <= pmr_pkg::DEVAD_RESET;
        mmd_addr_q[i] <= pmr_pkg::MMD_ADDR_RESET;
      end
    end
    else
    begin
      ack_q    <= ack_d;
      rdata_q  <= rdata_d;
      shared_q <= shared_d;
      ctrl_q   <= ctrl_d;
      for (int i = 0; i < NUM_PHY; i++)
      begin
        fn_q[i]       <= fn_d[i];
        devad_q[i]    <= devad_d[i];
        mmd_addr_q[i] <= mmd_addr_d[i];
      end
    end
  end

  assign mgmt_ack_out    = ack_q;
  assign mgmt_rdata_out  = rdata_q;
  assign phy_ctrl_out    = ctrl_q;
  assign shared_ctrl_out = shared_q;

endmodule

// ===== rtl/pmr_pkg.sv
package pmr_pkg;

  localparam int          NUM_PHY       = 8;
  localparam logic [4:0]  PHY_BASE_ADDR = 5'h08;

  // Management register numbers
  localparam logic [4:0]  REG_PARTNER_BASE  = 5'h05;
  localparam logic [4:0]  REG_NEG_EXPANSION = 5'h06;
  localparam logic [4:0]  REG_NP_TRANSMIT   = 5'h07;
  localparam logic [4:0]  REG_PARTNER_NP    = 5'h08;
  localparam logic [4:0]  REG_MMD_CONTROL   = 5'h0d;
  localparam logic [4:0]  REG_MMD_ADDR_DATA = 5'h0e;
  localparam logic [4:0]  REG_SPECIAL_CTRL  = 5'h10;
  localparam logic [4:0]  REG_SPECIAL_STAT  = 5'h12;
  localparam logic [4:0]  REG_PAGE_CONTROL  = 5'h14;

  // Indirect device and register numbers
  localparam logic [4:0]  MMD_DEV_PCS       = 5'h03;
  localparam logic [4:0]  MMD_DEV_AN        = 5'h07;
  localparam logic [15:0] MMD_PCS_CONTROL1  = 16'h0000;
  localparam logic [15:0] MMD_PCS_STATUS1   = 16'h0001;
  localparam logic [15:0] MMD_EEE_CAP       = 16'h0014;
  localparam logic [15:0] MMD_WAKE_ERR      = 16'h0016;
  localparam logic [15:0] MMD_EEE_ADV       = 16'h003c;
  localparam logic [15:0] MMD_EEE_PARTNER   = 16'h003d;

  // Field positions
  localparam int BIT_NP             = 15;
  localparam int BIT_NPT_RSVD       = 14;
  localparam int BIT_REMOTE_FAULT   = 13;
  localparam int BIT_MSG_PAGE       = 13;
  localparam int BIT_BASE_RSVD      = 12;
  localparam int BIT_ACK2           = 12;
  localparam int BIT_TOGGLE         = 11;
  localparam int BIT_ASYM_PAUSE     = 11;
  localparam int BIT_SYM_PAUSE      = 10;
  localparam int MSG_MSB            = 10;
  localparam int BIT_PDF            = 4;
  localparam int BIT_PARTNER_NP     = 3;
  localparam int BIT_NP_ABLE        = 2;
  localparam int BIT_PAGE_RX        = 1;
  localparam int BIT_PARTNER_AN     = 0;
  localparam int FN_MSB             = 15;
  localparam int FN_LSB             = 14;
  localparam int DEVAD_MSB          = 4;
  localparam int BIT_APS            = 7;
  localparam int BIT_FEF_DISABLE    = 4;
  localparam int BIT_LINK_UP        = 14;
  localparam int BIT_SPEED_100      = 11;
  localparam int BIT_FULL_DUPLEX    = 10;
  localparam int BIT_CLK_STOP       = 10;
  localparam int BIT_TX_LPI_LATCH   = 11;
  localparam int BIT_RX_LPI_LATCH   = 10;
  localparam int BIT_TX_LPI_NOW     = 9;
  localparam int BIT_RX_LPI_NOW     = 8;
  localparam int BIT_EEE_100TX      = 1;
  localparam int PAGE_SEL_MSB       = 4;

  // Reset and fixed values
  localparam logic [15:0] NPT_RESET        = 16'h2001;
  localparam logic [4:0]  PAGE_SEL_RESET   = 5'h00;
  localparam logic        APS_RESET        = 1'b1;
  localparam logic        FEF_RESET        = 1'b0;
  localparam logic        CLK_STOP_RESET   = 1'b0;
  localparam logic        EEE_ADV_RESET    = 1'b1;
  localparam logic [15:0] WAKE_CNT_RESET   = 16'h0000;
  localparam logic [4:0]  DEVAD_RESET      = 5'h00;
  localparam logic [15:0] MMD_ADDR_RESET   = 16'h0000;
  localparam logic [15:0] EEE_CAP_VALUE    = 16'h0002;
  localparam logic [4:0]  PAGE_PRIMARY     = 5'h00;

  typedef enum logic [1:0] {
    MMD_FN_ADDR,
    MMD_FN_DATA,
    MMD_FN_DATA_INC_RW,
    MMD_FN_DATA_INC_WR
  } pmr_mmd_fn_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [4:0]  phy_addr;
    logic [4:0]  reg_addr;
    logic [15:0] wdata;
  } pmr_mgmt_req_t;

  typedef struct packed {
    logic [15:0] partner_base;
    logic [15:0] partner_next_page;
    logic        page_received;
    logic        parallel_fault;
    logic        local_an_enable;
    logic        partner_an_able;
    logic        fiber_100mb_mode;
    logic        toggle;
    logic        link_up;
    logic        speed_100;
    logic        full_duplex;
    logic        tx_lpi;
    logic        rx_lpi;
    logic        wake_error;
    logic        eee_partner_100tx;
    logic [1:0]  local_pause_adv;
  } pmr_phy_status_t;

  typedef struct packed {
    logic [15:0] next_page_word;
    logic        remote_fault;
    logic [1:0]  pause_resolved;
    logic        clock_stop_enable;
    logic        eee_adv_100tx;
  } pmr_phy_ctrl_t;

  typedef struct packed {
    logic        advanced_power_saving;
    logic        far_end_fault_disable;
    logic [4:0]  upper_register_page_select;
  } pmr_shared_ctrl_t;

endpackage

// ===== rtl/pmr_sticky.sv
`timescale 1ns/10ps
module pmr_sticky
(
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      q_out
);

  logic q_q;
  logic q_d;

  // Set beats clear so an event in the read cycle survives
  always_comb
  begin
    q_d = set_in | (q_q & ~clr_in);
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      q_q <= 1'b0;
    else
      q_q <= q_d;
  end

  assign q_out = q_q;

endmodule

// ===== rtl/pmr_sat_counter.sv
`timescale 1ns/10ps
module pmr_sat_counter #(
  parameter int WIDTH = 16
)
(
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  input  wire logic             inc_in,
  input  wire logic             clr_in,
  output logic      [WIDTH-1:0] count_out
);

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (clr_in)
      cnt_d = inc_in ? WIDTH'(1) : '0;
    else if (inc_in && cnt_q != '1)
      cnt_d = cnt_q + WIDTH'(1);
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  assign count_out = cnt_q;

endmodule

// ===== dv/pmr_checker.sv
`timescale 1ns/10ps
module pmr_checker #(
  parameter int         NUM_PHY  = 8,
  parameter logic [4:0] PHY_BASE = 5'h08
)
(
  input wire logic                                   clock_in,
  input wire logic                                   rst_n_in,
  input wire pmr_pkg::pmr_mgmt_req_t                 mgmt_in,
  input wire pmr_pkg::pmr_phy_status_t [NUM_PHY-1:0] phy_status_in,
  input wire logic                                   mgmt_ack_out,
  input wire logic [15:0]                            mgmt_rdata_out,
  input wire pmr_pkg::pmr_phy_ctrl_t [NUM_PHY-1:0]   phy_ctrl_out,
  input wire pmr_pkg::pmr_shared_ctrl_t              shared_ctrl_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  logic                      hit;
  logic                      wr;
  logic                      rd0;
  logic [4:0]                ra;
  pmr_pkg::pmr_phy_status_t  s0;
  pmr_pkg::pmr_phy_ctrl_t    c0;
  pmr_pkg::pmr_shared_ctrl_t sh;
  assign hit = mgmt_in.valid && mgmt_in.phy_addr >= PHY_BASE
    && mgmt_in.phy_addr < PHY_BASE + NUM_PHY;
  assign wr = hit && mgmt_in.write;
  assign rd0 = hit && !mgmt_in.write && mgmt_in.phy_addr == PHY_BASE;
  assign ra = mgmt_in.reg_addr;
  assign s0 = phy_status_in[0];
  assign c0 = phy_ctrl_out[0];
  assign sh = shared_ctrl_out;
  sequence s_ack;
    ##1 mgmt_ack_out;
  endsequence
  property p_ack;
    hit |-> s_ack;
  endproperty
  a_ack: assert property (p_ack)
    else $error("missing ack");
  property p_rf;
    1'b1 |=> c0.remote_fault == $past(s0.partner_base[13]);
  endproperty
  a_rf: assert property (p_rf)
    else $error("remote fault wrong");
  property p_pause;
    !s0.local_an_enable |=> c0.pause_resolved == $past(s0.local_pause_adv);
  endproperty
  a_pause: assert property (p_pause)
    else $error("pause wrong");
  property p_page;
    wr && ra == 5'h14 |=> sh.upper_register_page_select
      == $past(mgmt_in.wdata[4:0]);
  endproperty
  a_page: assert property (p_page)
    else $error("page select wrong");
  property p_spc;
    wr && ra == 5'h10 && sh.upper_register_page_select == 5'h00 |=>
      sh.advanced_power_saving == $past(mgmt_in.wdata[7])
      && sh.far_end_fault_disable == $past(mgmt_in.wdata[4]);
  endproperty
  a_spc: assert property (p_spc)
    else $error("special control wrong");
  property p_np;
    hit && !mgmt_in.write && ra == 5'h06 |-> s_ack ##0
      mgmt_rdata_out[2] && mgmt_rdata_out[15:5] == 11'h000;
  endproperty
  a_np: assert property (p_np)
    else $error("expansion wrong");
  property p_stat;
    rd0 && ra == 5'h12 && sh.upper_register_page_select == 5'h00 |=>
      mgmt_rdata_out[14] == $past(s0.link_up)
      && mgmt_rdata_out[11] == $past(s0.speed_100);
  endproperty
  a_stat: assert property (p_stat)
    else $error("special status wrong");
  property p_rst;
    $rose(rst_n_in) |-> sh.advanced_power_saving && !sh.far_end_fault_disable
      && !c0.clock_stop_enable && c0.eee_adv_100tx;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset value wrong");
endmodule

bind pmr_phy_mgmt_regs pmr_checker #(
  .NUM_PHY  (NUM_PHY),
  .PHY_BASE (PHY_BASE)
) pmr_checker_inst (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .mgmt_in(mgmt_in),
  .phy_status_in(phy_status_in), .mgmt_ack_out(mgmt_ack_out),
  .mgmt_rdata_out(mgmt_rdata_out), .phy_ctrl_out(phy_ctrl_out),
  .shared_ctrl_out(shared_ctrl_out));

// ===== dv/pmr_mgmt_master.sv
`timescale 1ns/10ps
module pmr_mgmt_master
(
  input  wire logic             clock_in,
  output pmr_pkg::pmr_mgmt_req_t mgmt_out
);
  initial mgmt_out = '0;
  // One-cycle pulse; only documented locations are used
  task automatic xfer(input logic w, input logic [4:0] p, r,
                      input logic [15:0] d);
    @(posedge clock_in);
    #1 mgmt_out = '{1'b1, w, p, r, d};
    @(posedge clock_in);
    #1 mgmt_out.valid = 1'b0;
  endtask
endmodule

// ===== dv/phy_mgmt_register_bank_tb.sv
`timescale 1ns/10ps
module phy_mgmt_register_bank_tb;
  logic                           clock_in = 1'b0;
  logic                           rst_n_in = 1'b0;
  pmr_pkg::pmr_mgmt_req_t         mreq;
  pmr_pkg::pmr_phy_status_t [7:0] st = '0;
  logic                           ack;
  logic [15:0]                    rdata;
  pmr_pkg::pmr_phy_ctrl_t [7:0]   ctrl;
  pmr_pkg::pmr_shared_ctrl_t      sh;
  logic [15:0]                    exp_q[$];
  logic [15:0]                    v;
  logic [2:0]                     k;
  int                             errors = 0;
  int                             total_checks = 0;
  int                             cyc = 0;
  pmr_mgmt_master pmr_mgmt_master_inst (.clock_in(clock_in), .mgmt_out(mreq));
  pmr_phy_mgmt_regs pmr_phy_mgmt_regs_inst (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .mgmt_in(mreq),
    .phy_status_in(st), .mgmt_ack_out(ack), .mgmt_rdata_out(rdata),
    .phy_ctrl_out(ctrl), .shared_ctrl_out(sh));
  always #10 clock_in = ~clock_in;
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Foreign addresses get no answer, so nothing is expected
  task automatic rd(input logic [4:0] p, r, input logic [15:0] e);
    if (p[4:3] == 2'b01)
      exp_q.push_back(e);
    pmr_mgmt_master_inst.xfer(1'b0, p, r, 16'h0000);
  endtask
  task automatic wr(input logic [4:0] r, input logic [15:0] d);
    exp_q.push_back(16'h0000);
    pmr_mgmt_master_inst.xfer(1'b1, 5'h08, r, d);
  endtask
  task automatic mmd(input logic [4:0] dv, input logic [15:0] a,
                     input logic [1:0] fn);
    wr(5'h0d, {11'h000, dv});
    wr(5'h0e, a);
    wr(5'h0d, {fn, 9'h000, dv});
  endtask
  always @(posedge clock_in)
    if (ack === 1'b1)
      chk(rdata, exp_q.size() > 0 ? exp_q.pop_front() : 16'hdead);
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      summarize();
    end
  end
  initial
  begin
    v = 16'($urandom(45775));
    repeat (16) @(posedge clock_in);
    #1 rst_n_in = 1'b1;
    for (int i = 0; i < 8; i++)
      st[i].local_an_enable = 1'b1;
    for (int i = 0; i < 8; i++)
      st[i].partner_an_able = 1'b1;
    st[0].local_pause_adv = 2'b10;
    rd(5'h08, 5'h07, 16'h2001);
    rd(5'h08, 5'h10, 16'h0080);
    wr(5'h07, 16'hffff);
    st[0].toggle = 1'b1;
    rd(5'h08, 5'h07, 16'hbfff);
    k = 3'($urandom) | 3'h1;
    v = 16'($urandom);
    st[k].partner_next_page = v;
    st[k].partner_base = v;
    rd({2'b01, k}, 5'h08, v);
    chk(16'(ctrl[k].remote_fault), 16'(v[13]));
    st[k].partner_an_able = 1'b0;
    rd({2'b01, k}, 5'h05, (v & 16'hefff) | 16'h0c00);
    st[0].parallel_fault = 1'b1;
    st[0].partner_base = 16'h2000;
    st[0].page_received = 1'b1;
    @(posedge clock_in);
    #1 st[0].parallel_fault = 1'b0;
    st[0].page_received = 1'b0;
    rd(5'h08, 5'h06, 16'h0017);
    chk(16'(ctrl[0].remote_fault), 16'h0001);
    rd(5'h08, 5'h06, 16'h0005);
    st[0].fiber_100mb_mode = 1'b1;
    rd(5'h08, 5'h06, 16'h0004);
    st[0].local_an_enable = 1'b0;
    st[0].link_up = 1'b1;
    st[0].speed_100 = 1'b1;
    st[0].full_duplex = 1'b1;
    rd(5'h08, 5'h12, 16'h4c00);
    chk(16'(ctrl[0].pause_resolved), 16'h0002);
    wr(5'h14, 16'h0003);
    rd(5'h0f, 5'h10, 16'h0000);
    rd(5'h0f, 5'h14, 16'h0003);
    wr(5'h14, 16'h0000);
    wr(5'h10, 16'h0010);
    chk(16'(sh.far_end_fault_disable), 16'h0001);
    mmd(5'h03, 16'h0014, 2'b01);
    rd(5'h08, 5'h0e, 16'h0002);
    rd(5'h08, 5'h0e, 16'h0002);
    mmd(5'h03, 16'h0000, 2'b10);
    wr(5'h0e, 16'hffff);
    st[0].tx_lpi = 1'b1;
    st[0].rx_lpi = 1'b1;
    @(posedge clock_in);
    #1 st[0].tx_lpi = 1'b0;
    rd(5'h08, 5'h0e, 16'h0d00);
    rd(5'h08, 5'h0e, 16'h0000);
    chk(16'(ctrl[0].clock_stop_enable), 16'h0001);
    mmd(5'h03, 16'h0016, 2'b01);
    st[0].wake_error = 1'b1;
    repeat (3) @(posedge clock_in);
    #1 st[0].wake_error = 1'b0;
    rd(5'h08, 5'h0e, 16'h0003);
    rd(5'h08, 5'h0e, 16'h0000);
    mmd(5'h07, 16'h003c, 2'b11);
    st[0].eee_partner_100tx = 1'b1;
    wr(5'h0e, 16'h0000);
    rd(5'h08, 5'h0e, 16'h0002);
    rd(5'h08, 5'h0e, 16'h0002);
    rd(5'h08, 5'h0d, 16'hc007);
    chk(16'(ctrl[0].eee_adv_100tx), 16'h0000);
    rd(5'h00, 5'h05, 16'h0000);
    repeat (4) @(posedge clock_in);
    chk(16'(exp_q.size()), 16'h0000);
    summarize();
  end
endmodule
